// [rtl/dnwc_pkg.sv]
// Shared constants and types for the data nonvolatile write controller.
package dnwc_pkg;
    localparam int CLK_MHZ          = 40;
    localparam int POWERUP_DELAY_US = 1000;
    localparam int POWERUP_CYCLES   = POWERUP_DELAY_US * CLK_MHZ;
    localparam int ERASE_TIME_US    = 2;
    localparam int ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_TIME_US     = 2;
    localparam int PROG_CYCLES      = PROG_TIME_US * CLK_MHZ;

    localparam logic [1:0] SEL_ADDR = 2'h0;
    localparam logic [1:0] SEL_BYTE = 2'h1;
    localparam logic [1:0] SEL_KEY  = 2'h2;
    localparam logic [1:0] SEL_CTRL = 2'h3;

    localparam int BIT_RD    = 0;
    localparam int BIT_WR    = 1;
    localparam int BIT_ALLOW = 2;
    localparam int BIT_ABORT = 3;
    localparam int BIT_FREE  = 4;
    localparam int BIT_CFG   = 6;
    localparam int BIT_PGM   = 7;

    localparam logic [7:0] KEY_FIRST   = 8'h55;
    localparam logic [7:0] KEY_SECOND  = 8'haa;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] KEY_READ    = 8'h00;

    typedef enum logic [1:0] {UNL_IDLE, UNL_HALF, UNL_ARMED} dnwc_unlock_t;
    typedef enum logic [1:0] {ENG_IDLE, ENG_ERASE, ENG_PROG} dnwc_eng_t;
endpackage

// [rtl/dnwc_mem_if.sv]
// Array port between the controller and the nonvolatile byte array.
`timescale 1ns/100ps
`default_nettype none
interface dnwc_mem_if #(
    parameter int AW = 8,
    parameter int DW = 8
);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [rtl/dnwc_nvm_array.sv]
// Byte array with one port and registered read data.
`timescale 1ns/100ps
`default_nettype none
module dnwc_nvm_array #(
    parameter int DEPTH = 256
) (
    input  wire logic mclk_i,
    input  wire logic ce_i,
    dnwc_mem_if.mem   port
);
    // The cells hold their contents across resets, so they carry no reset.
    logic [7:0] cell_q [DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge mclk_i) begin
        if (ce_i && port.en) begin
            if (port.we) begin
                cell_q[port.addr] <= port.wdata;
            end else begin
                rdata_q <= cell_q[port.addr];
            end
        end
    end

    assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// [rtl/dnwc_data_nvm_ctrl.sv]
// Unlock-gated self-timed write controller for the nonvolatile data array.
`timescale 1ns/100ps
`default_nettype none
module dnwc_data_nvm_ctrl #(
    parameter int POWERUP_CYCLES = dnwc_pkg::POWERUP_CYCLES,
    parameter int ERASE_CYCLES   = dnwc_pkg::ERASE_CYCLES,
    parameter int PROG_CYCLES    = dnwc_pkg::PROG_CYCLES
) (
    input  wire logic       mclk_i,
    input  wire logic       ce_i,
    input  wire logic       sys_rst_i,
    input  wire logic       por_i,
    input  wire logic [1:0] sfr_sel_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       done_clr_i,
    output logic            store_done_flag_o,
    output logic            write_busy_o,
    input  wire logic       code_protect_i,
    input  wire logic       ext_req_i,
    input  wire logic       ext_we_i,
    input  wire logic [7:0] ext_addr_i,
    input  wire logic [7:0] ext_wdata_i,
    output logic            ext_ack_o,
    output logic            ext_refused_o,
    output logic      [7:0] ext_rdata_o
);
    localparam int CMAX = (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
    localparam int CW   = $clog2(CMAX + 1);
    localparam int PW   = $clog2(POWERUP_CYCLES + 1);

    typedef struct packed {
        logic [7:0]            addr;
        logic [7:0]            byte_v;
        logic                  pgm;
        logic                  cfg;
        logic                  free;
        logic                  abort;
        logic                  allow;
        logic                  wr;
        logic                  rd;
        logic                  done;
        dnwc_pkg::dnwc_unlock_t unl;
        dnwc_pkg::dnwc_eng_t   eng;
        logic [CW-1:0]         cnt;
        logic [PW-1:0]         pu_cnt;
        logic                  pu_done;
        logic [7:0]            rdata;
        logic                  ext_ack;
        logic                  ext_ref;
    } dnwc_state_t;

    dnwc_state_t st_q;
    dnwc_state_t st_d;
    dnwc_mem_if #(.AW(8), .DW(8)) mem ();

    logic sfr_acc;
    logic wr_ctl;
    logic key_wr;
    logic ctl_ok;
    logic start;
    logic rd_go;
    logic erase_end;
    logic prog_end;
    logic ext_idle;
    logic ext_go;

    always_comb begin
        sfr_acc   = sfr_wr_i || sfr_rd_i;
        wr_ctl    = sfr_wr_i && (sfr_sel_i == dnwc_pkg::SEL_CTRL);
        key_wr    = sfr_wr_i && (sfr_sel_i == dnwc_pkg::SEL_KEY);
        ctl_ok    = wr_ctl && !st_q.wr;
        // The allow bit is taken from the register, never from this write.
        start     = ctl_ok && sfr_wdata_i[dnwc_pkg::BIT_WR]
                    && st_q.allow
                    && (st_q.unl == dnwc_pkg::UNL_ARMED)
                    && !st_q.pgm && !st_q.cfg
                    && st_q.pu_done;
        rd_go     = ctl_ok && sfr_wdata_i[dnwc_pkg::BIT_RD]
                    && !sfr_wdata_i[dnwc_pkg::BIT_PGM]
                    && !sfr_wdata_i[dnwc_pkg::BIT_CFG];
        erase_end = (st_q.eng == dnwc_pkg::ENG_ERASE) && (st_q.cnt == '0);
        prog_end  = (st_q.eng == dnwc_pkg::ENG_PROG) && (st_q.cnt == '0);
        ext_idle  = !st_q.ext_ack && !st_q.ext_ref;
        // External access waits while the CPU owns the array.
        ext_go    = ext_req_i && ext_idle && !code_protect_i && !st_q.wr && !rd_go;
    end

    always_comb begin
        st_d = st_q;
        mem.en    = 1'b0;
        mem.we    = 1'b0;
        mem.addr  = st_q.addr;
        mem.wdata = st_q.byte_v;
        st_d.ext_ack = 1'b0;
        st_d.ext_ref = 1'b0;

        if (!st_q.pu_done) begin
            st_d.pu_cnt = st_q.pu_cnt + 1'b1;
            if (st_q.pu_cnt == PW'(POWERUP_CYCLES - 1)) begin
                st_d.pu_done = 1'b1;
            end
        end

        if (st_q.rd) begin
            st_d.byte_v = mem.rdata;
            st_d.rd     = 1'b0;
        end

        if (sfr_rd_i) begin
            unique case (sfr_sel_i)
                dnwc_pkg::SEL_ADDR: st_d.rdata = st_q.addr;
                dnwc_pkg::SEL_BYTE: st_d.rdata = st_q.rd ? mem.rdata : st_q.byte_v;
                dnwc_pkg::SEL_KEY:  st_d.rdata = dnwc_pkg::KEY_READ;
                dnwc_pkg::SEL_CTRL: st_d.rdata = {st_q.pgm, st_q.cfg, 1'b0, st_q.free,
                                                  st_q.abort, st_q.allow, st_q.wr, st_q.rd};
            endcase
        end

        // Every access to the block is one step; a wrong one drops the tracker.
        if (sfr_acc) begin
            unique case (st_q.unl)
                dnwc_pkg::UNL_IDLE:
                    st_d.unl = (key_wr && sfr_wdata_i == dnwc_pkg::KEY_FIRST)
                               ? dnwc_pkg::UNL_HALF : dnwc_pkg::UNL_IDLE;
                dnwc_pkg::UNL_HALF:
                    st_d.unl = (key_wr && sfr_wdata_i == dnwc_pkg::KEY_SECOND)
                               ? dnwc_pkg::UNL_ARMED : dnwc_pkg::UNL_IDLE;
                dnwc_pkg::UNL_ARMED:
                    st_d.unl = dnwc_pkg::UNL_IDLE;
                default: st_d.unl = dnwc_pkg::UNL_IDLE;
            endcase
        end

        if (sfr_wr_i && !st_q.wr) begin
            unique case (sfr_sel_i)
                dnwc_pkg::SEL_ADDR: st_d.addr = sfr_wdata_i;
                dnwc_pkg::SEL_BYTE: st_d.byte_v = sfr_wdata_i;
                dnwc_pkg::SEL_KEY:  st_d.byte_v = st_d.byte_v;
                dnwc_pkg::SEL_CTRL: begin
                    st_d.pgm   = sfr_wdata_i[dnwc_pkg::BIT_PGM];
                    st_d.cfg   = sfr_wdata_i[dnwc_pkg::BIT_CFG];
                    st_d.free  = sfr_wdata_i[dnwc_pkg::BIT_FREE];
                    st_d.abort = sfr_wdata_i[dnwc_pkg::BIT_ABORT];
                    st_d.allow = sfr_wdata_i[dnwc_pkg::BIT_ALLOW];
                    if (rd_go) begin
                        st_d.rd = 1'b1;
                    end
                end
            endcase
        end

        if (rd_go) begin
            mem.en = 1'b1;
        end else if (ext_go) begin
            mem.en    = 1'b1;
            mem.we    = ext_we_i;
            mem.addr  = ext_addr_i;
            mem.wdata = ext_wdata_i;
        end
        if (ext_req_i && ext_idle && code_protect_i) begin
            st_d.ext_ref = 1'b1;
        end else if (ext_go) begin
            st_d.ext_ack = 1'b1;
        end

        // A clear in the finishing cycle loses to the hardware set.
        if (done_clr_i) begin
            st_d.done = 1'b0;
        end

        if (start) begin
            st_d.wr  = 1'b1;
            st_d.eng = dnwc_pkg::ENG_ERASE;
            st_d.cnt = CW'(ERASE_CYCLES - 1);
        end

        unique case (st_q.eng)
            dnwc_pkg::ENG_IDLE: st_d.cnt = st_d.cnt;
            dnwc_pkg::ENG_ERASE: begin
                st_d.cnt = st_q.cnt - 1'b1;
                if (erase_end) begin
                    mem.en    = 1'b1;
                    mem.we    = 1'b1;
                    mem.wdata = dnwc_pkg::ERASED_BYTE;
                    st_d.eng  = dnwc_pkg::ENG_PROG;
                    st_d.cnt  = CW'(PROG_CYCLES - 1);
                end
            end
            dnwc_pkg::ENG_PROG: begin
                st_d.cnt = st_q.cnt - 1'b1;
                if (prog_end) begin
                    mem.en     = 1'b1;
                    mem.we     = 1'b1;
                    st_d.eng   = dnwc_pkg::ENG_IDLE;
                    st_d.wr    = 1'b0;
                    st_d.done  = 1'b1;
                    st_d.abort = 1'b0;
                end
            end
            default: st_d.eng = dnwc_pkg::ENG_IDLE;
        endcase

        if (por_i) begin
            st_d = '0;
            mem.en = 1'b0;
        end else if (sys_rst_i) begin
            st_d = '0;
            st_d.pgm     = st_q.pgm;
            st_d.cfg     = st_q.cfg;
            st_d.allow   = st_q.allow;
            st_d.abort   = st_q.abort || st_q.wr;
            st_d.pu_cnt  = st_q.pu_cnt;
            st_d.pu_done = st_q.pu_done;
            mem.en = 1'b0;
        end
    end

    // Reset must act even while the clock enable holds everything else still.
    always_ff @(posedge mclk_i) begin
        if (ce_i || sys_rst_i || por_i) begin
            st_q <= st_d;
        end
    end

    dnwc_nvm_array #(.DEPTH(256)) u_array (
        .mclk_i (mclk_i),
        .ce_i   (ce_i),
        .port   (mem)
    );

    assign sfr_rdata_o       = st_q.rdata;
    assign store_done_flag_o = st_q.done;
    assign write_busy_o      = st_q.wr;
    assign ext_ack_o         = st_q.ext_ack;
    assign ext_refused_o     = st_q.ext_ref;
    assign ext_rdata_o       = mem.rdata;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i || por_i);

    sequence s_write_end;
        ce_i && prog_end;
    endsequence

    sequence s_read_req;
        ce_i && rd_go;
    endsequence

    a_unlock_second_key: assert property (
        ce_i && key_wr && sfr_wdata_i == dnwc_pkg::KEY_SECOND
        && st_q.unl == dnwc_pkg::UNL_HALF |=> st_q.unl == dnwc_pkg::UNL_ARMED)
        else $error("Second key did not arm the tracker.");
    a_start_needs_allow: assert property (
        ce_i && start |-> st_q.allow ##1 st_q.wr && st_q.eng == dnwc_pkg::ENG_ERASE)
        else $error("Write started without the allow bit.");
    a_same_write_refused: assert property (
        ce_i && ctl_ok && !st_q.wr && !st_q.allow && sfr_wdata_i[dnwc_pkg::BIT_WR]
        |=> !st_q.wr)
        else $error("Allow and start in one write started a write.");
    a_allow_sw_only: assert property (
        !$stable(st_q.allow) |-> $past(ctl_ok) || $past(por_i))
        else $error("Allow bit changed without a control write.");
    a_regs_locked: assert property (
        ce_i && st_q.wr && sfr_wr_i && sfr_sel_i == dnwc_pkg::SEL_ADDR
        |=> $stable(st_q.addr))
        else $error("Address register changed during a write.");
    a_write_done: assert property (
        s_write_end |=> st_q.done && !st_q.wr && st_q.eng == dnwc_pkg::ENG_IDLE)
        else $error("Write end did not set done and clear start.");
    a_flag_sticky: assert property (
        st_q.done && !done_clr_i && !sys_rst_i && !por_i |=> st_q.done)
        else $error("Done flag cleared without software.");
    a_protect_refuse: assert property (
        ce_i && ext_req_i && ext_idle && code_protect_i |-> !ext_go ##1 ext_refused_o && !ext_ack_o)
        else $error("Protected array answered an external access.");
    a_cpu_read_free: assert property (
        s_read_req |-> mem.en && !mem.we)
        else $error("CPU read did not reach the array.");
    a_pwrup_block: assert property (
        !st_q.pu_done |-> !st_q.wr)
        else $error("Write started inside the power-up delay.");
    a_data_space: assert property (
        ce_i && ctl_ok && sfr_wdata_i[dnwc_pkg::BIT_WR] && (st_q.pgm || st_q.cfg)
        |=> !st_q.wr)
        else $error("Write started with another space selected.");
    a_read_next: assert property (
        s_read_req ##1 (ce_i && !sfr_wr_i) |=> !st_q.rd && st_q.byte_v == $past(mem.rdata))
        else $error("Read data not loaded in the next cycle.");
    a_wr_set_only: assert property (
        st_q.wr && !(ce_i && prog_end) && !sys_rst_i && !por_i |=> st_q.wr)
        else $error("Write-start cleared before the write ended.");
    a_abort_trace: assert property (@(posedge mclk_i) disable iff (por_i)
        sys_rst_i && st_q.wr |=> st_q.abort && st_q.pgm == $past(st_q.pgm))
        else $error("Reset during a write left no abort trace.");
    a_unlock_drop: assert property (
        ce_i && sfr_acc && st_q.unl == dnwc_pkg::UNL_ARMED |=> st_q.unl == dnwc_pkg::UNL_IDLE)
        else $error("Tracker stayed armed after another access.");
    a_key_reads_zero: assert property (
        ce_i && sfr_rd_i && sfr_sel_i == dnwc_pkg::SEL_KEY |=> sfr_rdata_o == 8'h00)
        else $error("Key register read returned nonzero.");
endmodule
`default_nettype wire

// [verif/dnwc_ext_prog_model.sv]
// Model of an external programming port that reads and writes the array.
`timescale 1ns/100ps
`default_nettype none
module dnwc_ext_prog_model (
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       ext_ack_i,
    input  wire logic       ext_refused_i,
    input  wire logic [7:0] ext_rdata_i,
    output logic            ext_req_o,
    output logic            ext_we_o,
    output logic      [7:0] ext_addr_o,
    output logic      [7:0] ext_wdata_o,
    output logic            busy_o,
    output logic            ack_o,
    output logic            refused_o,
    output logic      [7:0] rdata_o
);
    logic       busy_q  = 1'h0;
    logic       ack_q   = 1'h0;
    logic       ref_q   = 1'h0;
    logic       we_q    = 1'h0;
    logic [7:0] addr_q  = 8'h00;
    logic [7:0] wdata_q = 8'h00;
    logic [7:0] rd_q    = 8'h00;
    // The request stands until the edge that samples the answer, then drops.
    assign ext_req_o   = busy_q;
    // Between requests the qualifiers show the inverse of the last value.
    assign ext_we_o    = busy_q ? we_q : ~we_q;
    assign ext_addr_o  = busy_q ? addr_q : ~addr_q;
    assign ext_wdata_o = busy_q ? wdata_q : ~wdata_q;
    assign busy_o      = busy_q;
    assign ack_o       = ack_q;
    assign refused_o   = ref_q;
    assign rdata_o     = rd_q;
    always @(posedge mclk_i) begin
        if (!busy_q && go_i) begin
            busy_q  <= 1'h1;
            we_q    <= we_i;
            addr_q  <= addr_i;
            wdata_q <= wdata_i;
        end else if (busy_q && (ext_ack_i || ext_refused_i)) begin
            busy_q <= 1'h0;
            ack_q  <= ext_ack_i;
            ref_q  <= ext_refused_i;
            rd_q   <= ext_rdata_i;
        end
    end
endmodule
`default_nettype wire

// [verif/test_data_nvm_write_controller.sv]
// Self-checking bench for the data nonvolatile write controller.
`timescale 1ns/100ps
`default_nettype none
module test_data_nvm_write_controller;
    logic       mclk_i    = 1'h0;
    logic       sys_rst_i = 1'h1;
    logic       por_i     = 1'h1;
    logic [1:0] sel       = 2'h0;
    logic       wr        = 1'h0;
    logic       rd        = 1'h0;
    logic [7:0] wdata     = 8'h00;
    logic       clr       = 1'h0;
    logic       prot      = 1'h0;
    logic       go        = 1'h0;
    logic       go_we     = 1'h0;
    logic [7:0] go_addr   = 8'h00;
    logic [7:0] go_data   = 8'h00;
    logic [7:0] rdata;
    logic       done;
    logic       busy;
    logic       x_req;
    logic       x_we;
    logic [7:0] x_addr;
    logic [7:0] x_wd;
    logic       x_ack;
    logic       x_ref;
    logic [7:0] x_rd;
    logic       m_busy;
    logic       m_ack;
    logic       m_ref;
    logic [7:0] m_rd;
    logic [7:0] v;
    int         err_total = 0;
    int         n_tests   = 0;

    always #12.5 mclk_i = ~mclk_i;

    dnwc_data_nvm_ctrl #(.POWERUP_CYCLES(8), .ERASE_CYCLES(3), .PROG_CYCLES(3)) dut_u (
        .mclk_i(mclk_i), .ce_i(1'h1), .sys_rst_i(sys_rst_i), .por_i(por_i),
        .sfr_sel_i(sel), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
        .sfr_rdata_o(rdata), .done_clr_i(clr), .store_done_flag_o(done),
        .write_busy_o(busy), .code_protect_i(prot), .ext_req_i(x_req), .ext_we_i(x_we),
        .ext_addr_i(x_addr), .ext_wdata_i(x_wd), .ext_ack_o(x_ack),
        .ext_refused_o(x_ref), .ext_rdata_o(x_rd));

    dnwc_ext_prog_model prog_u (
        .mclk_i(mclk_i), .go_i(go), .we_i(go_we), .addr_i(go_addr), .wdata_i(go_data),
        .ext_ack_i(x_ack), .ext_refused_i(x_ref), .ext_rdata_i(x_rd), .ext_req_o(x_req),
        .ext_we_o(x_we), .ext_addr_o(x_addr), .ext_wdata_o(x_wd), .busy_o(m_busy),
        .ack_o(m_ack), .refused_o(m_ref), .rdata_o(m_rd));

    task automatic tally_and_finish();
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk_byte(string nm, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_bit(string nm, logic exp, logic got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    // Each access holds the strobes for one cycle; the next call replaces them.
    task automatic acc(logic w, logic r, logic [1:0] s, logic [7:0] d);
        @(posedge mclk_i);
        wr    <= w;
        rd    <= r;
        sel   <= s;
        wdata <= d;
    endtask
    task automatic idle();
        @(posedge mclk_i);
        wr    <= 1'h0;
        rd    <= 1'h0;
        wdata <= ~wdata;
        #1;
    endtask
    task automatic rd_reg(logic [1:0] s, output logic [7:0] q);
        acc(1'h0, 1'h1, s, 8'h00);
        idle();
        q = rdata;
    endtask
    task automatic unlock();
        acc(1'h1, 1'h0, 2'h3, 8'h04);
        acc(1'h1, 1'h0, 2'h2, 8'h55);
        acc(1'h1, 1'h0, 2'h2, 8'haa);
        acc(1'h1, 1'h0, 2'h3, 8'h06);
        idle();
    endtask
    task automatic start_wr(logic [7:0] a, logic [7:0] d);
        acc(1'h1, 1'h0, 2'h0, a);
        acc(1'h1, 1'h0, 2'h1, d);
        unlock();
    endtask
    task automatic wait_idle();
        repeat (20) if (busy === 1'h1) begin
            @(posedge mclk_i);
            #1;
        end
        chk_bit("busy", 1'h0, busy);
    endtask
    task automatic clear_done();
        @(posedge mclk_i);
        clr <= 1'h1;
        @(posedge mclk_i);
        clr <= 1'h0;
        #1;
        chk_bit("done", 1'h0, done);
    endtask
    task automatic t_powerup();
        unlock();
        chk_bit("busy", 1'h0, busy);
        rd_reg(2'h3, v);
        chk_byte("ctrl", 8'h04, v);
        @(posedge mclk_i);
        por_i <= 1'h1;
        @(posedge mclk_i);
        por_i <= 1'h0;
        rd_reg(2'h3, v);
        chk_byte("ctrl", 8'h00, v);
        repeat (12) @(posedge mclk_i);
    endtask
    task automatic t_write();
        prot <= 1'h1;
        start_wr(8'h3c, 8'h5a);
        chk_bit("busy", 1'h1, busy);
        repeat (5) @(posedge mclk_i);
        #1;
        chk_bit("busy", 1'h1, busy);
        @(posedge mclk_i);
        #1;
        chk_bit("busy", 1'h0, busy);
        chk_bit("done", 1'h1, done);
        rd_reg(2'h3, v);
        chk_byte("ctrl", 8'h04, v);
        repeat (4) @(posedge mclk_i);
        #1;
        chk_bit("done", 1'h1, done);
        acc(1'h1, 1'h0, 2'h1, 8'h00);
        acc(1'h1, 1'h0, 2'h3, 8'h01);
        rd_reg(2'h1, v);
        chk_byte("byte", 8'h5a, v);
        rd_reg(2'h2, v);
        chk_byte("key", 8'h00, v);
        clear_done();
        prot <= 1'h0;
    endtask
    task automatic t_lock();
        start_wr(8'h10, 8'h11);
        acc(1'h1, 1'h0, 2'h0, 8'h20);
        acc(1'h1, 1'h0, 2'h1, 8'h22);
        acc(1'h1, 1'h0, 2'h3, 8'h00);
        idle();
        chk_bit("busy", 1'h1, busy);
        wait_idle();
        rd_reg(2'h0, v);
        chk_byte("addr", 8'h10, v);
        rd_reg(2'h1, v);
        chk_byte("byte", 8'h11, v);
        rd_reg(2'h3, v);
        chk_byte("ctrl", 8'h04, v);
        acc(1'h1, 1'h0, 2'h3, 8'h00);
        idle();
        clear_done();
    endtask
    task automatic bad(logic [7:0] c0, logic [7:0] k1, logic [7:0] k2, int gap,
                       logic [7:0] last);
        acc(1'h1, 1'h0, 2'h3, c0);
        acc(1'h1, 1'h0, 2'h2, k1);
        if (gap == 1) acc(1'h0, 1'h1, 2'h0, 8'h00);
        acc(1'h1, 1'h0, 2'h2, k2);
        if (gap == 2) acc(1'h0, 1'h1, 2'h0, 8'h00);
        acc(1'h1, 1'h0, 2'h3, last);
        idle();
        chk_bit("busy", 1'h0, busy);
        repeat (8) @(posedge mclk_i);
        #1;
        chk_bit("done", 1'h0, done);
    endtask
    task automatic t_bad();
        bad(8'h00, 8'h55, 8'haa, 0, 8'h02);
        bad(8'h00, 8'h55, 8'haa, 0, 8'h06);
        bad(8'h04, 8'haa, 8'h55, 0, 8'h06);
        bad(8'h04, 8'h55, 8'haa, 1, 8'h06);
        bad(8'h04, 8'h55, 8'haa, 2, 8'h06);
        bad(8'h44, 8'h55, 8'haa, 0, 8'h46);
        bad(8'h84, 8'h55, 8'haa, 0, 8'h86);
    endtask
    task automatic t_abort();
        start_wr(8'h50, 8'h66);
        @(posedge mclk_i);
        sys_rst_i <= 1'h1;
        @(posedge mclk_i);
        sys_rst_i <= 1'h0;
        #1;
        chk_bit("busy", 1'h0, busy);
        rd_reg(2'h3, v);
        chk_byte("ctrl", 8'h0c, v);
    endtask
    task automatic ext_op(logic w, logic [7:0] a, logic [7:0] d, logic acked);
        @(posedge mclk_i);
        go      <= 1'h1;
        go_we   <= w;
        go_addr <= a;
        go_data <= d;
        @(posedge mclk_i);
        go <= 1'h0;
        #1;
        repeat (10) if (m_busy === 1'h1) begin
            @(posedge mclk_i);
            #1;
        end
        chk_bit("ext_busy", 1'h0, m_busy);
        chk_bit("ext_ack", acked, m_ack);
        chk_bit("ext_refused", ~acked, m_ref);
    endtask
    task automatic t_ext();
        ext_op(1'h1, 8'h40, 8'h99, 1'h1);
        ext_op(1'h0, 8'h40, 8'h00, 1'h1);
        chk_byte("ext_rdata", 8'h99, m_rd);
        prot <= 1'h1;
        ext_op(1'h0, 8'h40, 8'h00, 1'h0);
        ext_op(1'h1, 8'h40, 8'h00, 1'h0);
        acc(1'h1, 1'h0, 2'h0, 8'h40);
        acc(1'h1, 1'h0, 2'h3, 8'h01);
        rd_reg(2'h1, v);
        chk_byte("byte", 8'h99, v);
        prot <= 1'h0;
    endtask

    initial begin
        repeat (3) @(posedge mclk_i);
        por_i     <= 1'h0;
        sys_rst_i <= 1'h0;
        t_powerup();
        t_write();
        t_lock();
        t_bad();
        t_abort();
        t_ext();
        tally_and_finish();
    end
    // A hang stops the run well after the whole sequence would have ended.
    initial begin
        #(25 * 5000);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
